// ---- rtl/lpms_sequencer.sv ----
// low power mode and reset sequencer: standby/halt entry and wake, reset timing
// assumes core, timers and watchdog give one-cycle event pulses on clk_sys
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps

module lpms_sequencer #(
    parameter int unsigned PWRUP0_CYC = lpms_pkg::PWRUP_140US_NS / lpms_pkg::CLK_PERIOD_NS,
    parameter int unsigned PWRUP1_CYC = lpms_pkg::PWRUP_4P5MS_NS / lpms_pkg::CLK_PERIOD_NS,
    parameter int unsigned PWRUP2_CYC = lpms_pkg::PWRUP_18MS_NS / lpms_pkg::CLK_PERIOD_NS,
    parameter int unsigned PWRUP3_CYC = lpms_pkg::PWRUP_72MS_NS / lpms_pkg::CLK_PERIOD_NS,
    parameter int unsigned PWRUP4_CYC = lpms_pkg::PWRUP_288MS_NS / lpms_pkg::CLK_PERIOD_NS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire lpms_pkg::lpms_wb_req_t wb_req,
    output lpms_pkg::lpms_wb_rsp_t wb_rsp,
    input wire logic por_event,
    input wire logic low_voltage_reset,
    input wire logic ext_reset_pin_n,
    input wire logic halt_instr,
    input wire logic watchdog_clear_instr,
    input wire logic global_int_on_instr,
    input wire logic global_int_off_instr,
    input wire lpms_pkg::lpms_wake_t wake_src,
    output logic sys_reset_n,
    output logic cpu_run,
    output logic high_osc_en,
    output logic low_osc_en,
    output logic high_clock_select,
    output logic [3:0] timer_en,
    output logic [2:0] module_en,
    output logic watchdog_run,
    output logic watchdog_clear,
    output logic wake_vector,
    output logic wake_continue
);
    import lpms_pkg::*;

    lpms_state_t state_reg;
    lpms_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [7:0] clock_control_reg;
    logic [7:0] enable_reg;
    logic [3:0] config_reg;
    logic power_down_flag;
    logic timeout_flag;
    logic gie_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic wdt_clear_reg;
    logic vector_reg;
    logic continue_reg;
    logic wr_fire;
    logic wr_clk_ctrl;
    logic [1:0] wr_mode;
    logic rst_event;
    logic wdt_reset;
    logic standby_wake;
    logic halt_wake;
    logic enter_halt;
    logic enter_standby;
    logic resume;
    logic in_halt;

    function automatic logic [CNT_W-1:0] pwrup_load(input logic [2:0] s);
        logic [CNT_W-1:0] r;
        r = CNT_W'(PWRUP4_CYC - 1);
        case (s)
            PWRUP_SEL_140US: r = CNT_W'(PWRUP0_CYC - 1);
            PWRUP_SEL_4P5MS: r = CNT_W'(PWRUP1_CYC - 1);
            PWRUP_SEL_18MS: r = CNT_W'(PWRUP2_CYC - 1);
            PWRUP_SEL_72MS: r = CNT_W'(PWRUP3_CYC - 1);
            default: r = CNT_W'(PWRUP4_CYC - 1);
        endcase
        return r;
    endfunction

    // register decode over classic wishbone, write lands on the ack edge
    assign wr_fire = wb_req.cyc && wb_req.stb && wb_req.we && ack_reg;
    assign wr_clk_ctrl = wr_fire && (wb_req.adr == ADR_CLK_CTRL) && wb_req.sel[0];
    assign wr_mode = wb_req.dat[CC_MODE_LSB +: 2];

    // reset sources
    assign in_halt = (state_reg == S_HALT) || (state_reg == S_WAKE);
    assign wdt_reset = wake_src.wdt_timeout && (state_reg == S_RUN);
    assign rst_event = por_event || low_voltage_reset || !ext_reset_pin_n
        || wdt_reset;

    // wake qualification
    assign standby_wake = |(wake_src.timer_expire & enable_reg[3:0])
        || wake_src.wdt_timeout || wake_src.port_change || (|wake_src.ext_irq_pins)
        || wake_src.lvd_irq || wake_src.cmp_irq || wake_src.adc_irq;
    assign halt_wake = wake_src.wdt_timeout || wake_src.port_change
        || (|wake_src.ext_irq_pins);

    assign enter_halt = (state_reg == S_RUN)
        && (halt_instr || (wr_clk_ctrl && wr_mode == OPM_HALT));
    assign enter_standby = (state_reg == S_RUN) && !halt_instr
        && wr_clk_ctrl && (wr_mode == OPM_STANDBY);

    // sequencing state
    always_comb begin
        state_next = state_reg;
        cnt_next = (cnt_reg != '0) ? cnt_reg - CNT_W'(1) : cnt_reg;
        resume = 1'b0;
        if (rst_event) begin
            state_next = S_RESET;
        end else begin
            case (state_reg)
                S_RESET: begin
                    state_next = S_PWRUP;
                    cnt_next = pwrup_load(config_reg[2:0]);
                end
                S_PWRUP: begin
                    if (cnt_reg == '0) begin
                        state_next = S_OST;
                        cnt_next = (config_reg[2:0] == PWRUP_SEL_140US) ?
                            CNT_W'(OST_SHORT_CYC - 1) : CNT_W'(OST_LONG_CYC - 1);
                    end
                end
                S_OST: begin
                    if (cnt_reg == '0) begin
                        state_next = S_RUN;
                    end
                end
                S_RUN: begin
                    if (enter_halt) begin
                        state_next = S_HALT;
                    end else if (enter_standby) begin
                        state_next = S_STANDBY;
                    end
                end
                S_STANDBY: begin
                    if (standby_wake) begin
                        state_next = S_RUN;
                        resume = 1'b1;
                    end
                end
                S_HALT: begin
                    if (halt_wake) begin
                        state_next = S_WAKE;
                        cnt_next = config_reg[CFG_XTAL_BIT] ?
                            CNT_W'(WAKE_XTAL_CYC - 1) : CNT_W'(WAKE_RC_CYC - 1);
                    end
                end
                S_WAKE: begin
                    if (cnt_reg == '0) begin
                        state_next = S_RUN;
                        resume = 1'b1;
                    end
                end
                default: begin
                    state_next = S_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= S_RESET;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // clock control and module enables
    always_ff @(posedge clk_sys) begin
        if (!rst_n || rst_event) begin
            clock_control_reg <= CC_RESET;
            enable_reg <= EN_RESET;
        end else begin
            if (wr_clk_ctrl) begin
                clock_control_reg[CC_SEL_HI_BIT] <= wb_req.dat[CC_SEL_HI_BIT];
                clock_control_reg[CC_STOP_HI_BIT] <= wb_req.dat[CC_STOP_HI_BIT];
            end
            if (state_next != state_reg) begin
                case (state_next)
                    S_HALT: clock_control_reg[CC_MODE_LSB +: 2] <= OPM_HALT;
                    S_STANDBY: clock_control_reg[CC_MODE_LSB +: 2] <= OPM_STANDBY;
                    default: clock_control_reg[CC_MODE_LSB +: 2] <= OPM_RUN;
                endcase
            end
            if (wr_fire && wb_req.adr == ADR_ENABLE && wb_req.sel[0]) begin
                enable_reg <= wb_req.dat[7:0];
            end
        end
    end

    // configuration survives reset events
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            config_reg <= CFG_RESET;
        end else if (wr_fire && wb_req.adr == ADR_CONFIG && wb_req.sel[0]) begin
            config_reg <= wb_req.dat[3:0];
        end
    end

    // timeout and power-down flags
    always_ff @(posedge clk_sys) begin
        if (!rst_n || por_event || low_voltage_reset) begin
            timeout_flag <= 1'b1;
            power_down_flag <= 1'b1;
        end else if (!ext_reset_pin_n) begin
            if (in_halt) begin
                timeout_flag <= 1'b1;
                power_down_flag <= 1'b1;
            end
        end else if (wdt_reset) begin
            timeout_flag <= 1'b0;
            power_down_flag <= 1'b1;
        end else if (state_reg == S_HALT && wake_src.wdt_timeout) begin
            timeout_flag <= 1'b0;
            power_down_flag <= 1'b0;
        end else if (enter_halt) begin
            timeout_flag <= 1'b1;
            power_down_flag <= 1'b0;
        end else if (watchdog_clear_instr && state_reg == S_RUN) begin
            timeout_flag <= 1'b1;
            power_down_flag <= 1'b1;
        end
    end

    // global interrupt enable and resume kind
    always_ff @(posedge clk_sys) begin
        if (!rst_n || rst_event) begin
            gie_reg <= 1'b0;
        end else if (global_int_on_instr) begin
            gie_reg <= 1'b1;
        end else if (global_int_off_instr) begin
            gie_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            vector_reg <= 1'b0;
            continue_reg <= 1'b0;
            wdt_clear_reg <= 1'b0;
        end else begin
            vector_reg <= resume && gie_reg && !rst_event;
            continue_reg <= resume && !gie_reg && !rst_event;
            wdt_clear_reg <= enter_halt && !rst_event;
        end
    end

    // wishbone answer: ack one cycle after strobe, unmapped reads give zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdat_reg <= '0;
        end else begin
            ack_reg <= wb_req.cyc && wb_req.stb && !ack_reg;
            rdat_reg <= '0;
            if (wb_req.cyc && wb_req.stb && !ack_reg) begin
                case (wb_req.adr)
                    ADR_CLK_CTRL: rdat_reg[7:0] <= clock_control_reg;
                    ADR_STATUS: begin
                        rdat_reg[ST_PD_BIT] <= power_down_flag;
                        rdat_reg[ST_TO_BIT] <= timeout_flag;
                        rdat_reg[ST_GIE_BIT] <= gie_reg;
                        rdat_reg[ST_RST_BIT] <= !sys_reset_n;
                    end
                    ADR_CONFIG: rdat_reg[3:0] <= config_reg;
                    ADR_ENABLE: rdat_reg[7:0] <= enable_reg;
                    default: rdat_reg <= '0;
                endcase
            end
        end
    end

    assign wb_rsp.ack = ack_reg;
    assign wb_rsp.dat = rdat_reg;

    // gating outputs
    assign sys_reset_n = !(state_reg == S_RESET || state_reg == S_PWRUP
        || state_reg == S_OST);
    assign cpu_run = (state_reg == S_RUN);
    assign high_osc_en = !in_halt && !clock_control_reg[CC_STOP_HI_BIT];
    assign low_osc_en = !in_halt;
    assign high_clock_select = clock_control_reg[CC_SEL_HI_BIT];
    assign timer_en = in_halt ? 4'h0 : enable_reg[3:0];
    assign module_en = in_halt ? 3'h0 : enable_reg[EN_MOD_LSB +: 3];
    assign watchdog_run = enable_reg[EN_WDT_BIT];
    assign watchdog_clear = wdt_clear_reg;
    assign wake_vector = vector_reg;
    assign wake_continue = continue_reg;

    // checks
    logic [CNT_W-1:0] dwell_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || state_next != state_reg) begin
            dwell_reg <= '0;
        end else begin
            dwell_reg <= dwell_reg + CNT_W'(1);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_standby_entry;
        enter_standby && !rst_event |=> state_reg == S_STANDBY ##0 cpu_run == 1'b0;
    endproperty
    a_standby_entry: assert property (p_standby_entry) else $error("standby not entered");

    property p_halt_entry;
        halt_instr && state_reg == S_RUN && !rst_event
            |=> state_reg == S_HALT && !power_down_flag && timeout_flag && watchdog_clear;
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt entry wrong");

    property p_halt_gating;
        state_reg == S_HALT |-> !high_osc_en && !low_osc_en && timer_en == 4'h0
            && module_en == 3'h0 && !cpu_run;
    endproperty
    a_halt_gating: assert property (p_halt_gating) else $error("halt gating wrong");

    property p_halt_only_wakes;
        state_reg == S_HALT && !halt_wake && !rst_event |=> state_reg == S_HALT;
    endproperty
    a_halt_only_wakes: assert property (p_halt_only_wakes) else $error("halt left");

    property p_wake_len;
        state_reg == S_WAKE && state_next == S_RUN |->
            dwell_reg == (config_reg[CFG_XTAL_BIT] ? CNT_W'(WAKE_XTAL_CYC - 1)
            : CNT_W'(WAKE_RC_CYC - 1));
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("wake wait length");

    property p_standby_wake;
        state_reg == S_STANDBY && standby_wake && !rst_event
            |=> cpu_run && (wake_vector || wake_continue);
    endproperty
    a_standby_wake: assert property (p_standby_wake) else $error("standby wake");

    property p_vector;
        resume && !rst_event |=> wake_vector == $past(gie_reg) && wake_continue != wake_vector;
    endproperty
    a_vector: assert property (p_vector) else $error("resume kind wrong");

    property p_reset_hold;
        rst_event |=> !sys_reset_n ##1 !sys_reset_n;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset not held");

    property p_ost_len;
        state_reg == S_OST && state_next == S_RUN |->
            dwell_reg == ((config_reg[2:0] == PWRUP_SEL_140US) ?
            CNT_W'(OST_SHORT_CYC - 1) : CNT_W'(OST_LONG_CYC - 1));
    endproperty
    a_ost_len: assert property (p_ost_len) else $error("start-up wait length");

    property p_wdt_reset_flags;
        wdt_reset && !por_event && !low_voltage_reset && ext_reset_pin_n
            |=> !timeout_flag && power_down_flag && !sys_reset_n;
    endproperty
    a_wdt_reset_flags: assert property (p_wdt_reset_flags) else $error("wdt flags");

    c_standby_wake: cover property (state_reg == S_STANDBY ##1 state_reg == S_RUN);
    c_halt_wake: cover property (state_reg == S_WAKE ##1 state_reg == S_RUN);
    c_reset_done: cover property (state_reg == S_OST ##1 state_reg == S_RUN);

endmodule

// ---- rtl/lpms_pkg.sv ----
// constants, types and register map of the low power mode and reset sequencer
// assumes one 100 MHz system clock and a classic wishbone master
package lpms_pkg;

    // clock and times in their own units
    localparam int CLK_PERIOD_NS = 10;
    localparam int PWRUP_140US_NS = 140000;
    localparam int PWRUP_4P5MS_NS = 4500000;
    localparam int PWRUP_18MS_NS = 18000000;
    localparam int PWRUP_72MS_NS = 72000000;
    localparam int PWRUP_288MS_NS = 288000000;

    // cycle counts of the system oscillator
    localparam int OST_SHORT_CYC = 1;
    localparam int OST_LONG_CYC = 16;
    localparam int WAKE_XTAL_CYC = 512;
    localparam int WAKE_RC_CYC = 16;
    localparam int CNT_W = 25;

    // register byte addresses
    localparam logic [7:0] ADR_CLK_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_CONFIG = 8'h08;
    localparam logic [7:0] ADR_ENABLE = 8'h0C;

    // clock_control_reg fields
    localparam int CC_SEL_HI_BIT = 0;
    localparam int CC_STOP_HI_BIT = 1;
    localparam int CC_MODE_LSB = 2;
    localparam logic [7:0] CC_RESET = 8'h01;

    // status fields
    localparam int ST_PD_BIT = 3;
    localparam int ST_TO_BIT = 4;
    localparam int ST_GIE_BIT = 5;
    localparam int ST_RST_BIT = 6;

    // config fields: [2:0] power-up time select, [3] crystal mode in use
    localparam int CFG_XTAL_BIT = 3;
    localparam logic [3:0] CFG_RESET = 4'h0;
    localparam logic [2:0] PWRUP_SEL_140US = 3'h0;
    localparam logic [2:0] PWRUP_SEL_4P5MS = 3'h1;
    localparam logic [2:0] PWRUP_SEL_18MS = 3'h2;
    localparam logic [2:0] PWRUP_SEL_72MS = 3'h3;

    // enable fields: [3:0] timer run bits, [4] watchdog on, [7:5] other modules
    localparam int EN_WDT_BIT = 4;
    localparam int EN_MOD_LSB = 5;
    localparam logic [7:0] EN_RESET = 8'h00;

    // operating mode codes
    localparam logic [1:0] OPM_RUN = 2'h0;
    localparam logic [1:0] OPM_HALT = 2'h1;
    localparam logic [1:0] OPM_STANDBY = 2'h2;

    typedef enum logic [2:0] {
        S_RESET, S_PWRUP, S_OST, S_RUN, S_STANDBY, S_HALT, S_WAKE
    } lpms_state_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } lpms_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } lpms_wb_rsp_t;

    typedef struct packed {
        logic [3:0] timer_expire;
        logic wdt_timeout;
        logic port_change;
        logic [1:0] ext_irq_pins;
        logic lvd_irq;
        logic cmp_irq;
        logic adc_irq;
    } lpms_wake_t;

endpackage

// ---- testbench/lpms_partner.sv ----
// partner model: core instruction pulses and wake event sources
// assumes the bench asks for one event at a time, one cycle each
`timescale 1ns/1ps
module lpms_partner (
    input wire logic clk_sys,
    input wire logic fire,
    input wire logic [3:0] code,
    output logic halt_instr,
    output logic watchdog_clear_instr,
    output logic global_int_on_instr,
    output logic global_int_off_instr,
    output lpms_pkg::lpms_wake_t wake_src
);
    import lpms_pkg::*;
    logic [14:0] pulse_reg = 15'h0000;
    // one-cycle pulse per request, never two events together
    always_ff @(posedge clk_sys) begin
        pulse_reg <= fire ? (15'h0001 << code) : 15'h0000;
    end
    assign halt_instr = pulse_reg[0];
    assign watchdog_clear_instr = pulse_reg[1];
    assign global_int_on_instr = pulse_reg[2];
    assign global_int_off_instr = pulse_reg[3];
    assign wake_src = {pulse_reg[7:4], pulse_reg[8], pulse_reg[9], pulse_reg[11:10],
                       pulse_reg[12], pulse_reg[13], pulse_reg[14]};
endmodule

// ---- testbench/tb.sv ----
// self-checking bench of the power mode and reset sequencer
// assumes short power-up counts and the partner model for events
`timescale 1ns/1ps
module tb;
    import lpms_pkg::*;
    logic clk_sys = 0, rst_n = 0, por_event = 0, low_voltage_reset = 0, ext_reset_pin_n = 1;
    logic fire = 0, sys_reset_n, cpu_run, high_osc_en, low_osc_en, high_clock_select;
    logic watchdog_run, watchdog_clear, wake_vector, wake_continue;
    logic halt_instr, watchdog_clear_instr, global_int_on_instr, global_int_off_instr;
    logic [3:0] code = 0, timer_en;
    logic [2:0] module_en, seen3;
    logic [7:0] rd, en_val = 8'hB7;
    lpms_wb_req_t wb_req = '0;
    lpms_wb_rsp_t wb_rsp;
    lpms_wake_t wake_src;
    int mismatches = 0, n_checks = 0, n, j, k;
    always #5 clk_sys = ~clk_sys;
    lpms_sequencer #(.PWRUP0_CYC(20), .PWRUP1_CYC(30), .PWRUP2_CYC(40), .PWRUP3_CYC(50),
        .PWRUP4_CYC(60)) i_lpms_sequencer (.clk_sys(clk_sys), .rst_n(rst_n), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .por_event(por_event), .low_voltage_reset(low_voltage_reset),
        .ext_reset_pin_n(ext_reset_pin_n), .halt_instr(halt_instr),
        .watchdog_clear_instr(watchdog_clear_instr), .global_int_on_instr(global_int_on_instr),
        .global_int_off_instr(global_int_off_instr), .wake_src(wake_src),
        .sys_reset_n(sys_reset_n), .cpu_run(cpu_run), .high_osc_en(high_osc_en),
        .low_osc_en(low_osc_en), .high_clock_select(high_clock_select), .timer_en(timer_en),
        .module_en(module_en), .watchdog_run(watchdog_run), .watchdog_clear(watchdog_clear),
        .wake_vector(wake_vector), .wake_continue(wake_continue));
    lpms_partner i_lpms_partner (.clk_sys(clk_sys), .fire(fire), .code(code),
        .halt_instr(halt_instr), .watchdog_clear_instr(watchdog_clear_instr),
        .global_int_on_instr(global_int_on_instr),
        .global_int_off_instr(global_int_off_instr), .wake_src(wake_src));
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task tmo;
        mismatches++;
        $display("ERROR wait bound expected 0 seen 1");
        final_report;
    endtask
    task wb(input logic we, input logic [7:0] adr, input logic [7:0] d);
        int w;
        w = 0;
        wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, {24'h0, d}};
        do begin
            @(posedge clk_sys);
            w++;
        end while (wb_rsp.ack !== 1'b1 && w < 20);
        if (w >= 20) tmo;
        rd = wb_rsp.dat[7:0];
        wb_req <= '0;
        @(posedge clk_sys);
    endtask
    task ev(input logic [3:0] c);
        fire <= 1'b1;
        code <= c;
        @(posedge clk_sys);
        fire <= 1'b0;
        @(posedge clk_sys);
    endtask
    task wait_run;
        n = 0;
        while (cpu_run !== 1'b1 && n < 1000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 1000) tmo;
    endtask
    task grab(input int w);
        seen3 = {watchdog_clear, wake_vector, wake_continue};
        repeat (w) begin
            @(posedge clk_sys);
            seen3 = seen3 | {watchdog_clear, wake_vector, wake_continue};
        end
    endtask
    task reset_evt(input int w);
        case (w)
            0: por_event <= 1'b1;
            1: low_voltage_reset <= 1'b1;
            default: ext_reset_pin_n <= 1'b0;
        endcase
        @(posedge clk_sys);
        por_event <= 1'b0;
        low_voltage_reset <= 1'b0;
        ext_reset_pin_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        wait_run;
        n = n + 3;
        wb(1, ADR_ENABLE, en_val);
    endtask
    task sleep_wake(input logic [7:0] ctrl, input logic [3:0] c);
        wb(1, ADR_CLK_CTRL, ctrl);
        @(posedge clk_sys);
        chk("run off", 0, cpu_run);
        wb(0, ADR_CLK_CTRL, 0);
        chk("mode field", ctrl[3:2], rd[3:2]);
        if (ctrl[3]) begin
            chk("sb timers", en_val[3:0], timer_en);
            chk("sb modules", en_val[7:5], module_en);
            chk("sb high osc", !ctrl[1], high_osc_en);
            chk("sb low osc", 1, low_osc_en);
            ev(7);
            @(posedge clk_sys);
            chk("timer off no wake", 0, cpu_run);
        end else begin
            chk("halt outs", 0, {timer_en, module_en, high_osc_en, low_osc_en});
            chk("halt wdt runs", 1, watchdog_run);
            wb(0, ADR_STATUS, 0);
            chk("halt flags", 2'b10, rd[4:3]);
            for (k = 4; k < 15; k++) if (k < 8 || k > 11) ev(k[3:0]);
            @(posedge clk_sys);
            chk("halt ignores", 0, cpu_run);
        end
        ev(c);
        wait_run;
    endtask
    task t_reset;
        wait_run;
        chk("pwrup short", 1, n >= 21 && n <= 24);
        chk("sys reset", 1, sys_reset_n);
        wb(0, ADR_CLK_CTRL, 0);
        chk("clk ctrl init", CC_RESET, rd);
        wb(0, ADR_CONFIG, 0);
        chk("config init", CFG_RESET, rd);
        wb(0, ADR_ENABLE, 0);
        chk("enable init", EN_RESET, rd);
        wb(0, ADR_STATUS, 0);
        chk("flags por", 2'b11, rd[4:3]);
        wb(0, 8'h10, 8'h00);
        chk("unmapped", 0, rd);
        chk("high select", 1, high_clock_select);
        $display("t_reset done");
    endtask
    task t_standby;
        wb(1, ADR_ENABLE, en_val);
        for (j = 4; j < 15; j++) if (j != 7) begin
            sleep_wake(8'h09, j[3:0]);
            chk("sb wake", 1, n);
        end
        wb(1, ADR_CLK_CTRL, 8'h00);
        wb(1, ADR_CLK_CTRL, 8'h02);
        sleep_wake(8'h0A, 4'd9);
        chk("slow resume", 0, high_clock_select);
        wb(0, ADR_CLK_CTRL, 0);
        chk("mode back", 0, rd[3:2]);
        ev(2);
        sleep_wake(8'h09, 4'd10);
        grab(3);
        chk("vector", 3'b010, seen3);
        ev(3);
        sleep_wake(8'h09, 4'd11);
        grab(3);
        chk("continue", 3'b001, seen3);
        $display("t_standby done");
    endtask
    task t_halt;
        ev(0);
        grab(3);
        chk("wdt clear", 3'b100, seen3);
        wb(0, ADR_STATUS, 0);
        chk("sleep flags", 2'b10, rd[4:3]);
        chk("halt outs", 0, {timer_en, module_en, high_osc_en, low_osc_en});
        ev(9);
        wait_run;
        chk("rc wake", 1, n >= 16 && n <= 19);
        for (j = 8; j < 12; j++) begin
            sleep_wake(8'h05, j[3:0]);
            chk("halt wake", 1, n >= 16 && n <= 19);
        end
        wb(1, ADR_CONFIG, 8'h08);
        wb(1, ADR_CLK_CTRL, 8'h00);
        sleep_wake(8'h06, 4'd10);
        chk("xtal wake", 1, n >= 512 && n <= 515);
        chk("slow after halt", 0, high_clock_select);
        chk("stop kept", 0, high_osc_en);
        wb(1, ADR_CONFIG, 8'h00);
        $display("t_halt done");
    endtask
    task t_flags;
        ev(1);
        wb(0, ADR_STATUS, 0);
        chk("clear instr", 2'b11, rd[4:3]);
        sleep_wake(8'h05, 4'd8);
        wb(1, ADR_STATUS, 8'hFF);
        wb(0, ADR_STATUS, 0);
        chk("wdt from halt", 2'b00, rd[4:3]);
        reset_evt(2);
        chk("pin restart", 1, n >= 21 && n <= 26);
        wb(0, ADR_STATUS, 0);
        chk("pin in run", 2'b00, rd[4:3]);
        ev(8);
        repeat (3) @(posedge clk_sys);
        wait_run;
        wb(0, ADR_STATUS, 0);
        chk("wdt in run", 2'b01, rd[4:3]);
        wb(1, ADR_CLK_CTRL, 8'h05);
        @(posedge clk_sys);
        reset_evt(2);
        wb(0, ADR_STATUS, 0);
        chk("pin from halt", 2'b11, rd[4:3]);
        wb(1, ADR_CONFIG, 8'h01);
        sleep_wake(8'h05, 4'd8);
        reset_evt(0);
        chk("pwrup long", 1, n >= 46 && n <= 51);
        sleep_wake(8'h05, 4'd8);
        reset_evt(1);
        wb(0, ADR_STATUS, 0);
        chk("lvr flags", 2'b11, rd[4:3]);
        $display("t_flags done");
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_standby;
        t_halt;
        t_flags;
        final_report;
    end
endmodule
